// File: rtl/ssp_flags_regs.svh
// Register offsets, field positions and reset values of the serial port flags
`ifndef SSP_FLAGS_REGS_SVH
`define SSP_FLAGS_REGS_SVH
`define ADDR_STATUS     8'h13
`define ADDR_CONTROL    8'h14
`define ADDR_BUFFER     8'h15
`define ADDR_IRQ_STAT   8'h16
`define ADDR_IRQ_MASK   8'h17
`define CTL_COLL_BIT    7
`define CTL_OVF_BIT     6
`define CTL_EN_BIT      5
`define CTL_POL_BIT     4
`define CTL_MODE_MSB    3
`define CTL_RESET       8'h00
`define STAT_RESET      8'h00
`define IRQ_RESET       8'h00
`define MODE_I2C_MIN    4'h6
`define BYTE_BITS       4'h8
`define IRQ_RX_BIT      0
`define IRQ_TX_BIT      1
`define IRQ_OVF_BIT     2
`define IRQ_COLL_BIT    3
`define IRQ_ADDR_BIT    4
`endif

// File: rtl/ssp_flags_pkg.sv
// Types shared by the serial port flags block
package ssp_flags_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b10
  } xfer_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       ack;
    logic       addr_match;
    logic       rw_bit;
  } i2c_evt_s;
endpackage : ssp_flags_pkg

// File: rtl/serial_port_status_flags.sv
// Serial port status flags, control register and transfer buffer
//
// Functional notes
// - I2C: latch address byte direction bit on match; 1 read, 0 write.
// - Direction flag valid only until next start, stop or acknowledge.
// - Buffer-full sets when a received byte lands in the buffer.
// - I2C transmit: buffer-full stays 1 while loaded byte shifts out.
// - I2C transmit: buffer-full clears once the byte has shifted out.
// - SPI: byte arriving over unread buffer sets overflow and is dropped.
// - Port enable hands clock and data pins to the port, else GPIO.
`timescale 1ns/1ps
`include "ssp_flags_regs.svh"

module serial_port_status_flags
  import ssp_flags_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rx_done_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       bit_shifted_i,
  input  wire logic       i2c_start_i,
  input  wire logic       i2c_stop_i,
  input  wire logic       i2c_ack_i,
  input  wire logic       i2c_addr_match_i,
  input  wire logic       i2c_rw_bit_i,
  output logic [7:0]      rdata_o,
  output logic            tx_load_o,
  output logic [7:0]      tx_byte_o,
  output logic            pins_to_port_o,
  output logic            irq_o
);

  reg_req_s    req;
  i2c_evt_s    evt;
  xfer_state_e state_ff;
  logic [7:0]  ctl_ff;
  logic [7:0]  buf_ff;
  logic        full_ff;
  logic        dir_ff;
  logic        dir_valid_ff;
  logic [3:0]  bitcnt_ff;
  logic [4:0]  irq_stat_ff;
  logic [4:0]  irq_mask_ff;
  logic [4:0]  nxt_irq_ev;
  logic        en;
  logic        i2c_mode;
  logic        busy;
  logic        buf_wr;
  logic        buf_rd;
  logic        rx_keep;
  logic        rx_ovf;
  logic        tx_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  assign req      = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign evt      = '{start: i2c_start_i, stop: i2c_stop_i, ack: i2c_ack_i,
                      addr_match: i2c_addr_match_i, rw_bit: i2c_rw_bit_i};
  assign en       = ctl_ff[`CTL_EN_BIT];
  assign i2c_mode = (ctl_ff[`CTL_MODE_MSB:0] >= `MODE_I2C_MIN);
  assign busy     = (state_ff != ST_IDLE);
  assign buf_wr   = req.wr && hit(req.addr, `ADDR_BUFFER);
  assign buf_rd   = req.rd && hit(req.addr, `ADDR_BUFFER);
  // Overflow only in SPI; I2C receive with a full buffer also drops the byte
  assign rx_keep  = en && rx_done_i && !full_ff;
  assign rx_ovf   = en && rx_done_i && full_ff && !i2c_mode;
  assign tx_done  = (state_ff == ST_TX) && bit_shifted_i &&
                    (bitcnt_ff == `BYTE_BITS - 4'h1);

  // Transfer state: write to buffer starts a transmit, otherwise stays idle; ST_RX is never entered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !en) begin
      state_ff  <= ST_IDLE;
      bitcnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (buf_wr) begin
            state_ff  <= ST_TX;
            bitcnt_ff <= 4'h0;
          end
        end
        ST_TX: begin
          if (tx_done) begin
            state_ff  <= ST_IDLE;
            bitcnt_ff <= 4'h0;
          end else if (bit_shifted_i) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Buffer-full flag; a fresh byte wins over a read in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !en) begin
      full_ff <= 1'b0;
    end else if (rx_keep) begin
      full_ff <= 1'b1;
    end else if (buf_wr && !busy && i2c_mode) begin
      full_ff <= 1'b1;
    end else if (tx_done && i2c_mode) begin
      full_ff <= 1'b0;
    end else if (buf_rd && !busy) begin
      full_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      buf_ff <= 8'h00;
    end else if (rx_keep) begin
      buf_ff <= rx_byte_i;
    end else if (buf_wr && !busy && en) begin
      buf_ff <= req.wdata;
    end
  end

  // Direction flag and its validity window
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !en) begin
      dir_ff       <= 1'b0;
      dir_valid_ff <= 1'b0;
    end else if (i2c_mode && evt.addr_match) begin
      dir_ff       <= evt.rw_bit;
      dir_valid_ff <= 1'b1;
    end else if (evt.start || evt.stop || evt.ack) begin
      dir_ff       <= 1'b0;
      dir_valid_ff <= 1'b0;
    end
  end

  // Control register; hardware-set flags win over a software write of 0
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctl_ff <= `CTL_RESET;
    end else begin
      if (req.wr && hit(req.addr, `ADDR_CONTROL)) begin
        ctl_ff <= req.wdata;
      end
      if (buf_wr && busy) begin
        ctl_ff[`CTL_COLL_BIT] <= 1'b1;
      end
      if (rx_ovf) begin
        ctl_ff[`CTL_OVF_BIT] <= 1'b1;
      end
    end
  end

  always_comb begin
    nxt_irq_ev = 5'h00;
    nxt_irq_ev[`IRQ_RX_BIT]   = rx_keep;
    nxt_irq_ev[`IRQ_TX_BIT]   = tx_done;
    nxt_irq_ev[`IRQ_OVF_BIT]  = rx_ovf;
    nxt_irq_ev[`IRQ_COLL_BIT] = buf_wr && busy;
    nxt_irq_ev[`IRQ_ADDR_BIT] = i2c_mode && evt.addr_match && en;
  end

  // Sticky interrupt status, cleared by reading it; new events survive read
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 5'h00;
    end else if (req.rd && hit(req.addr, `ADDR_IRQ_STAT)) begin
      irq_stat_ff <= nxt_irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | nxt_irq_ev;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= 5'h00;
    end else if (req.wr && hit(req.addr, `ADDR_IRQ_MASK)) begin
      irq_mask_ff <= req.wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_stat_ff | nxt_irq_ev) & irq_mask_ff);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!req.rd) begin
      rdata_o <= 8'h00;
    end else if (hit(req.addr, `ADDR_STATUS)) begin
      rdata_o <= {5'h00, dir_ff, 1'b0, full_ff};
    end else if (hit(req.addr, `ADDR_CONTROL)) begin
      rdata_o <= ctl_ff;
    end else if (hit(req.addr, `ADDR_BUFFER)) begin
      rdata_o <= buf_ff;
    end else if (hit(req.addr, `ADDR_IRQ_STAT)) begin
      rdata_o <= {3'h0, irq_stat_ff};
    end else if (hit(req.addr, `ADDR_IRQ_MASK)) begin
      rdata_o <= {3'h0, irq_mask_ff};
    end else begin
      rdata_o <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_load_o      <= 1'b0;
      tx_byte_o      <= 8'h00;
      pins_to_port_o <= 1'b0;
    end else begin
      tx_load_o      <= buf_wr && !busy && en;
      tx_byte_o      <= (buf_wr && !busy && en) ? req.wdata : tx_byte_o;
      pins_to_port_o <= en;
    end
  end

  a_full_clr_dis: assert property (
    @(posedge ref_clk_i) disable iff (rst_i) !en |=> !full_ff)
    else $error("buffer-full set while disabled");
  a_full_on_rx: assert property (
    @(posedge ref_clk_i) disable iff (rst_i) rx_keep |=> full_ff)
    else $error("received byte did not set full");
  a_dir_latch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && i2c_mode && evt.addr_match) |=> (dir_ff == $past(evt.rw_bit)))
    else $error("direction not latched");
  a_dir_window: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && !evt.addr_match && (evt.start || evt.stop || evt.ack))
    |=> !dir_valid_ff) else $error("direction valid after bus event");
  a_tx_hold_full: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && i2c_mode && buf_wr && !busy) |=> full_ff && busy)
    else $error("transmit load did not set full");
  a_tx_done_clr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (en && i2c_mode && tx_done && !rx_keep) |=> !full_ff && !busy)
    else $error("full not cleared after shift-out");
  // A software buffer write in the same cycle is legal and may still land
  a_ovf_drop: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_ovf |=> ctl_ff[`CTL_OVF_BIT] && (buf_ff == (($past(buf_wr) &&
    !$past(busy)) ? $past(wdata_i) : $past(buf_ff))))
    else $error("overflow not flagged or byte kept");
  a_pins_follow: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ##1 pins_to_port_o == $past(en)) else $error("pin handover wrong");
  // A byte received during the transfer may land; only the write is refused
  a_coll_set: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (buf_wr && busy) |=> ctl_ff[`CTL_COLL_BIT] && (buf_ff ==
    ($past(rx_keep) ? $past(rx_byte_i) : $past(buf_ff))))
    else $error("collision not flagged");

  c_rx_byte: cover property (@(posedge ref_clk_i) rx_keep);
  c_tx_done: cover property (@(posedge ref_clk_i) tx_done && i2c_mode);
  c_overflow: cover property (@(posedge ref_clk_i) rx_ovf);
  c_collision: cover property (@(posedge ref_clk_i) buf_wr && busy);

endmodule : serial_port_status_flags

// File: tb/bus_master_model.sv
// Serial bus master model driving the shifter and I2C event inputs
`timescale 1ns/1ps
module bus_master_model
  import ssp_flags_pkg::*;
(
  input  wire logic       clk_i,
  output logic            rx_done_o,
  output logic [7:0]      rx_byte_o,
  output logic            shift_o,
  output i2c_evt_s        evt_o
);
  initial begin
    rx_done_o = 1'b0;
    rx_byte_o = 8'h00;
    shift_o   = 1'b0;
    evt_o     = '0;
  end

  // Byte lines flip once stale so a late capture cannot pass by luck
  task automatic recv(input logic [7:0] b);
    rx_done_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_byte_o <= ~b;
    @(posedge clk_i);
  endtask : recv

  // A gap after every bit: the master is slow on purpose
  task automatic shift(input int n);
    repeat (n) begin
      shift_o <= 1'b1;
      @(posedge clk_i);
      shift_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask : shift

  task automatic event_pulse(input i2c_evt_s ev);
    evt_o <= ev;
    @(posedge clk_i);
    evt_o <= {4'h0, ~ev.rw_bit};
    @(posedge clk_i);
  endtask : event_pulse
endmodule : bus_master_model

// File: tb/tb_serial_port_status_flags.sv
// Self-checking bench for the serial port status flags block
`timescale 1ns/1ps
`include "ssp_flags_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb_serial_port_status_flags
  import ssp_flags_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  reg_req_s   req = '0;
  i2c_evt_s   evt;
  logic [7:0] rdata, tx_byte, rx_byte, b, e;
  logic       rx_done, shift, tx_load, pins, irq, rd_d;
  int         fails = 0;
  int         n_checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] tx_q[$];

  always #5 clk = ~clk;

  serial_port_status_flags uut (
    .ref_clk_i(clk), .rst_i(rst), .addr_i(req.addr), .wdata_i(req.wdata),
    .wr_i(req.wr), .rd_i(req.rd), .rx_done_i(rx_done), .rx_byte_i(rx_byte),
    .bit_shifted_i(shift), .i2c_start_i(evt.start), .i2c_stop_i(evt.stop),
    .i2c_ack_i(evt.ack), .i2c_addr_match_i(evt.addr_match),
    .i2c_rw_bit_i(evt.rw_bit), .rdata_o(rdata), .tx_load_o(tx_load),
    .tx_byte_o(tx_byte), .pins_to_port_o(pins), .irq_o(irq));

  bus_master_model pm (.clk_i(clk), .rx_done_o(rx_done),
    .rx_byte_o(rx_byte), .shift_o(shift), .evt_o(evt));

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    req <= '{addr: a, wdata: w ? d : 8'h00, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : acc

  task automatic stop_test;
    if (exp_q.size() + tx_q.size() != 0) fails++;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Read data and loaded bytes are matched against the oldest note
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
    if (tx_load) begin
      e = tx_q.pop_front();
      `CHK("tx_byte", e, tx_byte)
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test;
  end

  initial begin
    void'($urandom(54));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(0, `ADDR_STATUS, `STAT_RESET);
    acc(0, `ADDR_CONTROL, `CTL_RESET);
    acc(0, `ADDR_IRQ_STAT, `IRQ_RESET);
    acc(0, `ADDR_IRQ_MASK, `IRQ_RESET);
    acc(0, 8'h20, 8'h00);
    $display("test reset done");
    acc(1, `ADDR_CONTROL, 8'h26);
    acc(1, `ADDR_IRQ_MASK, 8'h1F);
    @(negedge clk) `CHK("pins", 1'b1, pins)
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      pm.event_pulse(5'b00011);
      acc(0, `ADDR_STATUS, 8'h04);
      pm.event_pulse(5'b10000 >> i);
      acc(0, `ADDR_STATUS, 8'h00);
    end
    pm.event_pulse(5'b00011);
    pm.event_pulse(5'b00010);
    acc(0, `ADDR_STATUS, 8'h00);
    @(negedge clk) `CHK("irq", 1'b1, irq)
    @(posedge clk);
    acc(0, `ADDR_IRQ_STAT, 8'h10);
    $display("test direction done");
    b = 8'($urandom);
    pm.recv(b);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(0, `ADDR_IRQ_STAT, 8'h01);
    @(negedge clk) `CHK("irq", 1'b0, irq)
    @(posedge clk);
    acc(0, `ADDR_BUFFER, b);
    acc(0, `ADDR_STATUS, 8'h00);
    $display("test receive done");
    acc(1, `ADDR_CONTROL, 8'h24);
    acc(1, `ADDR_IRQ_MASK, 8'h00);
    pm.recv(b);
    pm.recv(~b);
    @(negedge clk) `CHK("irq", 1'b0, irq)
    @(posedge clk);
    acc(0, `ADDR_CONTROL, 8'h64);
    acc(0, `ADDR_BUFFER, b);
    acc(0, `ADDR_IRQ_STAT, 8'h05);
    $display("test overflow done");
    acc(1, `ADDR_CONTROL, 8'h26);
    b = 8'($urandom);
    tx_q.push_back(b);
    acc(1, `ADDR_BUFFER, b);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_BUFFER, ~b);
    acc(0, `ADDR_CONTROL, 8'hA6);
    pm.shift(7);
    acc(0, `ADDR_STATUS, 8'h01);
    pm.shift(1);
    @(posedge clk);
    acc(0, `ADDR_STATUS, 8'h00);
    acc(0, `ADDR_IRQ_STAT, 8'h0A);
    $display("test transmit done");
    pm.recv(b);
    acc(0, `ADDR_STATUS, 8'h01);
    acc(1, `ADDR_CONTROL, 8'h06);
    acc(0, `ADDR_STATUS, 8'h00);
    @(negedge clk) `CHK("pins", 1'b0, pins)
    $display("test disable done");
    stop_test;
  end
endmodule : tb_serial_port_status_flags
